// ---- bsram_pkg.sv ----
// Shared constants, types and helpers of the burst SRAM port
`default_nettype none
package bsram_pkg;
    // ======================================================
    // Widths
    localparam int ADDR_W = 6;
    localparam int LANE_W = 9;
    localparam int DEF_DATA_W = 18;
    localparam int BURST_LEN = 4;
    localparam int WORD_W = 2;
    localparam int CNT_W = 4;
    localparam int SLOTS = 2;
    typedef logic [CNT_W-1:0] bsram_cnt_t;
    typedef logic [ADDR_W-1:0] bsram_addr_t;
    typedef logic [ADDR_W+WORD_W-1:0] bsram_idx_t;
    // ======================================================
    // Edge counts after the starting positive edge
    localparam bsram_cnt_t CNT_START = 4'h0;
    localparam bsram_cnt_t CNT_ONE = 4'h1;
    localparam bsram_cnt_t BURST_CNT = 4'h4;
    localparam bsram_cnt_t WR_FIRST_EDGE = 4'h2;
    localparam bsram_cnt_t RD_FIRST_EDGE = 4'h5;
    // ======================================================
    // Controller clock generator states
    typedef enum logic [1:0] {
        HK_RISE = 2'b00,
        HK_FALL = 2'b01,
        HK_RESUME = 2'b10,
        HK_STOP = 2'b11
    } bsram_clk_state_t;
    // ======================================================
    // Helpers
    function automatic logic in_burst(input bsram_cnt_t cnt, input bsram_cnt_t first);
        return (cnt >= first) && (cnt < first + BURST_CNT);
    endfunction
    function automatic logic [WORD_W-1:0] burst_word(input bsram_cnt_t cnt,
                                                     input bsram_cnt_t first);
        bsram_cnt_t diff;
        diff = cnt - first;
        return diff[WORD_W-1:0];
    endfunction
    function automatic bsram_idx_t mem_index(input bsram_addr_t addr,
                                             input logic [WORD_W-1:0] word);
        return {addr, word};
    endfunction
endpackage
`default_nettype wire

// ---- bsram_if.sv ----
// Pin bundle between the memory controller and the burst SRAM
`timescale 1ns/100ps
`default_nettype none
interface bsram_if #(parameter int DATA_W = bsram_pkg::DEF_DATA_W);
    localparam int BL = DATA_W / bsram_pkg::LANE_W;
    logic k;
    logic k_n;
    logic [bsram_pkg::ADDR_W-1:0] addr;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [BL-1:0] byte_lane_write_n;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rdata_oe_n;
    modport device (
        input k, k_n, addr, read_port_select_n, write_port_select_n,
        input byte_lane_write_n, wdata,
        output rdata, rdata_oe_n
    );
    modport host (
        output k, k_n, addr, read_port_select_n, write_port_select_n,
        output byte_lane_write_n, wdata,
        input rdata, rdata_oe_n
    );
endinterface
`default_nettype wire

// ---- bsram_device.sv ----
// Burst SRAM device end: burst tracking, lane-masked array and read port
// Notes on behaviour
// - Write words at K,K# of t+1, t+2
// - Read words start 2.5 cycles after request
// - Latch start address, walk four ascending words
// - Data in and out on both clocks
// - Same-type request on next K ignored
// - Previous initiating select is don't-care next
// - Reset: ports deselected, read outputs off
// - Controller stops clocks high; state kept
// - Narrow: two selects gate two lanes
// - Wide: four selects gate four lanes
// - All selects high: word left unchanged
// - Byte mask taken per data word
// - Both selected from idle: read first, alternate
`timescale 1ns/100ps
`default_nettype none
module bsram_burst_track import bsram_pkg::*; #(
    parameter bsram_cnt_t FIRST = WR_FIRST_EDGE
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Events
    input wire logic edge_i,
    input wire logic start_i,
    input wire bsram_addr_t addr_i,
    // Current beat
    output logic hit_o,
    output logic slot_o,
    output logic [WORD_W-1:0] word_o,
    output bsram_addr_t addr_o,
    output logic start_slot_o
);
    localparam bsram_cnt_t LAST = FIRST + BURST_CNT - CNT_ONE;
    logic [SLOTS-1:0] act_reg;
    bsram_cnt_t cnt_reg [SLOTS];
    bsram_addr_t addr_reg [SLOTS];
    logic sel_reg;

    assign start_slot_o = sel_reg;

    // ======================================================
    // Slot counters, one burst in flight per slot
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            act_reg <= '0;
            sel_reg <= 1'b0;
            cnt_reg <= '{default: CNT_START};
            addr_reg <= '{default: '0};
        end else if (edge_i) begin
            for (int s = 0; s < SLOTS; s++) begin
                if (act_reg[s]) begin
                    cnt_reg[s] <= cnt_reg[s] + CNT_ONE;
                    if (cnt_reg[s] + CNT_ONE == LAST) begin
                        act_reg[s] <= 1'b0;
                    end
                end
            end
            if (start_i) begin
                act_reg[sel_reg] <= 1'b1;
                cnt_reg[sel_reg] <= CNT_START;
                addr_reg[sel_reg] <= addr_i;
                sel_reg <= ~sel_reg;
            end
        end
    end

    // ======================================================
    // Beat of the edge being handled now
    always_comb begin
        hit_o = 1'b0;
        slot_o = 1'b0;
        word_o = '0;
        addr_o = '0;
        for (int s = 0; s < SLOTS; s++) begin
            if (act_reg[s] && in_burst(cnt_reg[s] + CNT_ONE, FIRST)) begin
                hit_o = edge_i;
                slot_o = 1'(s);
                word_o = burst_word(cnt_reg[s] + CNT_ONE, FIRST);
                addr_o = addr_reg[s];
            end
        end
    end
endmodule

module bsram_device import bsram_pkg::*; #(
    parameter int DATA_W = DEF_DATA_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Memory pins
    bsram_if.device mem_port
);
    localparam int BL = DATA_W / LANE_W;
    localparam int WORDS = (1 << ADDR_W) * BURST_LEN;
    logic k_prev_reg;
    logic k_n_prev_reg;
    logic last_rd_reg;
    logic last_wr_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic rdata_oe_n_reg;
    logic [DATA_W-1:0] mem [WORDS];
    logic pos_edge;
    logic neg_edge;
    logic any_edge;
    logic rd_ok;
    logic wr_ok;
    logic do_rd;
    logic do_wr;
    logic wr_hit;
    logic [WORD_W-1:0] wr_word;
    bsram_addr_t wr_addr;
    logic rd_hit;
    logic [WORD_W-1:0] rd_word;
    bsram_addr_t rd_addr;

    // ======================================================
    // Clock edge detection; stopped clocks give no edges
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            k_prev_reg <= 1'b1;
            k_n_prev_reg <= 1'b1;
        end else begin
            k_prev_reg <= mem_port.k;
            k_n_prev_reg <= mem_port.k_n;
        end
    end
    assign pos_edge = mem_port.k & ~k_prev_reg;
    assign neg_edge = mem_port.k_n & ~k_n_prev_reg;
    assign any_edge = pos_edge | neg_edge;

    // ======================================================
    // Request acceptance and arbitration
    assign rd_ok = pos_edge & ~mem_port.read_port_select_n & ~last_rd_reg;
    assign wr_ok = pos_edge & ~mem_port.write_port_select_n & ~last_wr_reg;
    assign do_rd = rd_ok;
    assign do_wr = wr_ok & ~rd_ok;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_rd_reg <= 1'b0;
            last_wr_reg <= 1'b0;
        end else if (pos_edge) begin
            last_rd_reg <= do_rd;
            last_wr_reg <= do_wr;
        end
    end

    // ======================================================
    // Burst schedules
    bsram_burst_track #(.FIRST(WR_FIRST_EDGE)) u_wr_track (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .edge_i(any_edge),
        .start_i(do_wr),
        .addr_i(mem_port.addr),
        .hit_o(wr_hit),
        .slot_o(),
        .word_o(wr_word),
        .addr_o(wr_addr),
        .start_slot_o()
    );

    bsram_burst_track #(.FIRST(RD_FIRST_EDGE)) u_rd_track (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .edge_i(any_edge),
        .start_i(do_rd),
        .addr_i(mem_port.addr),
        .hit_o(rd_hit),
        .slot_o(),
        .word_o(rd_word),
        .addr_o(rd_addr),
        .start_slot_o()
    );

    // ======================================================
    // Array write, one word per edge, masked per lane
    always_ff @(posedge clock_i) begin
        if (wr_hit) begin
            for (int l = 0; l < BL; l++) begin
                if (!mem_port.byte_lane_write_n[l]) begin
                    mem[mem_index(wr_addr, wr_word)][l*LANE_W +: LANE_W] <=
                        mem_port.wdata[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ======================================================
    // Read port; released on the first edge without a word
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= '0;
            rdata_oe_n_reg <= 1'b1;
        end else if (rd_hit) begin
            rdata_reg <= mem[mem_index(rd_addr, rd_word)];
            rdata_oe_n_reg <= 1'b0;
        end else if (any_edge) begin
            rdata_oe_n_reg <= 1'b1;
        end
    end

    assign mem_port.rdata = rdata_reg;
    assign mem_port.rdata_oe_n = rdata_oe_n_reg;
endmodule
`default_nettype wire

// ---- bsram_host.sv ----
// Memory controller end: clock pair, command issue, write beats, read capture
`timescale 1ns/100ps
`default_nettype none
module bsram_host import bsram_pkg::*; #(
    parameter int DATA_W = DEF_DATA_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Clock run control
    input wire logic run_i,
    // Requests
    input wire logic rd_req_i,
    input wire bsram_addr_t rd_addr_i,
    input wire logic wr_req_i,
    input wire bsram_addr_t wr_addr_i,
    input wire logic [BURST_LEN*DATA_W-1:0] wr_data_i,
    input wire logic [BURST_LEN*(DATA_W/LANE_W)-1:0] wr_lane_n_i,
    // Answers
    output logic rd_ack_o,
    output logic wr_ack_o,
    output logic rd_valid_o,
    output logic [BURST_LEN*DATA_W-1:0] rd_data_o,
    // Memory pins
    bsram_if.host mem_port
);
    localparam int BL = DATA_W / LANE_W;
    bsram_clk_state_t state_reg;
    bsram_clk_state_t state_next;
    logic k_reg;
    logic k_n_reg;
    logic rps_n_reg;
    logic wps_n_reg;
    bsram_addr_t addr_reg;
    logic [BL-1:0] lane_n_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic last_rd_reg;
    logic last_wr_reg;
    logic rd_ack_reg;
    logic wr_ack_reg;
    logic [DATA_W-1:0] wbuf [SLOTS][BURST_LEN];
    logic [BL-1:0] wlane [SLOTS][BURST_LEN];
    logic [1:0] edge_d_reg;
    logic [WORD_W-1:0] rd_cnt_reg;
    logic [BURST_LEN*DATA_W-1:0] rbuf_reg;
    logic rd_valid_reg;
    logic [BURST_LEN*DATA_W-1:0] rd_data_reg;
    logic edge_now;
    logic pos_now;
    logic issue_rd;
    logic issue_wr;
    logic wr_hit;
    logic wr_slot;
    logic [WORD_W-1:0] wr_word;
    logic start_slot;

    // ======================================================
    // Clock pair; a stop parks both lines high
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            HK_RISE: state_next = run_i ? HK_FALL : HK_STOP;
            HK_FALL: state_next = HK_RISE;
            HK_RESUME: state_next = HK_RISE;
            HK_STOP: state_next = run_i ? HK_RESUME : HK_STOP;
        endcase
    end
    assign edge_now = (state_reg != HK_STOP);
    assign pos_now = (state_next == HK_RISE);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= HK_STOP;
            k_reg <= 1'b1;
            k_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            k_reg <= (state_next == HK_RISE) || (state_next == HK_STOP);
            k_n_reg <= (state_next != HK_RISE);
        end
    end

    // ======================================================
    // Command issue, never the same type on adjacent K rises
    assign issue_rd = pos_now & rd_req_i & ~last_rd_reg;
    assign issue_wr = pos_now & wr_req_i & ~last_wr_reg & ~issue_rd;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rps_n_reg <= 1'b1;
            wps_n_reg <= 1'b1;
            addr_reg <= '0;
            last_rd_reg <= 1'b0;
            last_wr_reg <= 1'b0;
            rd_ack_reg <= 1'b0;
            wr_ack_reg <= 1'b0;
        end else begin
            rd_ack_reg <= issue_rd;
            wr_ack_reg <= issue_wr;
            if (pos_now) begin
                rps_n_reg <= ~issue_rd;
                wps_n_reg <= ~issue_wr;
                addr_reg <= issue_rd ? rd_addr_i : wr_addr_i;
                last_rd_reg <= issue_rd;
                last_wr_reg <= issue_wr;
            end else begin
                rps_n_reg <= 1'b1;
                wps_n_reg <= 1'b1;
            end
        end
    end

    // ======================================================
    // Write beats on the four edges after the next
    bsram_burst_track #(.FIRST(WR_FIRST_EDGE)) u_wr_track (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .edge_i(edge_now),
        .start_i(issue_wr),
        .addr_i(wr_addr_i),
        .hit_o(wr_hit),
        .slot_o(wr_slot),
        .word_o(wr_word),
        .addr_o(),
        .start_slot_o(start_slot)
    );

    always_ff @(posedge clock_i) begin
        if (issue_wr) begin
            for (int w = 0; w < BURST_LEN; w++) begin
                wbuf[start_slot][w] <= wr_data_i[w*DATA_W +: DATA_W];
                wlane[start_slot][w] <= wr_lane_n_i[w*BL +: BL];
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdata_reg <= '0;
            lane_n_reg <= '1;
        end else if (wr_hit) begin
            wdata_reg <= wbuf[wr_slot][wr_word];
            lane_n_reg <= wlane[wr_slot][wr_word];
        end else if (edge_now) begin
            lane_n_reg <= '1;
        end
    end

    // ======================================================
    // Read capture, two clocks after each created edge
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            edge_d_reg <= '0;
            rd_cnt_reg <= '0;
            rbuf_reg <= '0;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
        end else begin
            edge_d_reg <= {edge_d_reg[0], edge_now};
            rd_valid_reg <= 1'b0;
            if (edge_d_reg[1] && !mem_port.rdata_oe_n) begin
                rbuf_reg[rd_cnt_reg*DATA_W +: DATA_W] <= mem_port.rdata;
                rd_cnt_reg <= rd_cnt_reg + WORD_W'(CNT_ONE);
                if (rd_cnt_reg == WORD_W'(BURST_LEN - 1)) begin
                    rd_valid_reg <= 1'b1;
                    rd_data_reg <= {mem_port.rdata, rbuf_reg[(BURST_LEN-1)*DATA_W-1:0]};
                end
            end
        end
    end

    assign mem_port.k = k_reg;
    assign mem_port.k_n = k_n_reg;
    assign mem_port.addr = addr_reg;
    assign mem_port.read_port_select_n = rps_n_reg;
    assign mem_port.write_port_select_n = wps_n_reg;
    assign mem_port.byte_lane_write_n = lane_n_reg;
    assign mem_port.wdata = wdata_reg;
    assign rd_ack_o = rd_ack_reg;
    assign wr_ack_o = wr_ack_reg;
    assign rd_valid_o = rd_valid_reg;
    assign rd_data_o = rd_data_reg;
endmodule
`default_nettype wire

// ---- bsram_port_props.sv ----
// Checker of the pin protocol between controller and burst SRAM
`timescale 1ns/100ps
`default_nettype none
module bsram_port_props import bsram_pkg::*; #(
    parameter int DATA_W = DEF_DATA_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Memory pins
    input wire logic k,
    input wire logic k_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [DATA_W/LANE_W-1:0] byte_lane_write_n,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rdata_oe_n
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    // ==========================================================
    // Requests seen at a K edge
    sequence s_rd;
        $rose(k) && !read_port_select_n;
    endsequence
    sequence s_wr;
        $rose(k) && !write_port_select_n;
    endsequence
    // ==========================================================
    // Properties
    property p_rd_once;
        s_rd |-> ##2 read_port_select_n;
    endproperty
    property p_wr_once;
        s_wr |-> ##2 write_port_select_n;
    endproperty
    property p_rd_latency;
        s_rd |-> ##6 (!rdata_oe_n)[*4];
    endproperty
    property p_rd_release;
        s_rd ##4 ($rose(k) && read_port_select_n) |-> ##6 rdata_oe_n;
    endproperty
    property p_wr_lanes_off;
        s_wr ##4 ($rose(k) && write_port_select_n) |-> ##2 (&byte_lane_write_n);
    endproperty
    property p_clk_never_low;
        k || k_n;
    endproperty
    property p_stop_exit;
        (k && k_n) |=> k_n;
    endproperty
    property p_clk_pair;
        $rose(k) |=> $rose(k_n);
    endproperty
    property p_reset_idle;
        $rose(reset_n_i) |-> rdata_oe_n && read_port_select_n && write_port_select_n;
    endproperty
    // ==========================================================
    // Assertions
    a_rd_once: assert property (p_rd_once) else $error("read select held twice");
    a_wr_once: assert property (p_wr_once) else $error("write select held twice");
    a_rd_latency: assert property (p_rd_latency) else $error("read data late");
    a_rd_release: assert property (p_rd_release) else $error("read port not released");
    a_wr_lanes_off: assert property (p_wr_lanes_off) else $error("lanes left on");
    a_clk_never_low: assert property (p_clk_never_low) else $error("both clocks low");
    a_stop_exit: assert property (p_stop_exit) else $error("bad clock restart");
    a_clk_pair: assert property (p_clk_pair) else $error("K edge without K# edge");
    a_reset_idle: assert property (p_reset_idle) else $error("pins busy at reset");
    // ==========================================================
    // Coverage
    c_rd: cover property (s_rd);
    c_wr: cover property (s_wr);
    c_stop: cover property (k && k_n ##1 k && k_n);
endmodule
`default_nettype wire

// ---- burst4_sep_io_sram_port_test.sv ----
// Self-checking bench: controller and burst SRAM joined over the pin bundle
`timescale 1ns/100ps
`default_nettype none
module burst4_sep_io_sram_port_test import bsram_pkg::*;;
    localparam int DW = 36;
    localparam int BW = BURST_LEN * DW;
    localparam int LW = BURST_LEN * DW / LANE_W;
    localparam logic [BW-1:0] D1 = {36'h8_7654_3210, 36'h1_2345_6789, 36'hF_EDCB_A987,
                                    36'h0_1357_9BDF};
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic run_i = 1'b1;
    logic rd_req_i = 1'b0;
    logic wr_req_i = 1'b0;
    bsram_addr_t rd_addr_i = 6'h00;
    bsram_addr_t wr_addr_i = 6'h00;
    logic [BW-1:0] wr_data_i = '0;
    logic [LW-1:0] wr_lane_n_i = '1;
    logic rd_ack_o;
    logic wr_ack_o;
    logic rd_valid_o;
    logic [BW-1:0] rd_data_o;
    logic [BW-1:0] mem5;
    // Narrow pair runs in lockstep on the low words and lanes of the same requests
    localparam int NDW = 18;
    localparam int NBW = BURST_LEN * NDW;
    localparam int NLW = BURST_LEN * NDW / LANE_W;
    logic n_rd_ack_o;
    logic n_wr_ack_o;
    logic n_rd_valid_o;
    logic [NBW-1:0] n_rd_data_o;
    int errors = 0;
    int n_checks = 0;
    always #2 clock_i = ~clock_i;
    // ==========================================================
    // Ends and checker
    bsram_if #(.DATA_W(DW)) mem_bus ();
    bsram_device #(.DATA_W(DW)) u_bsram_device (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .mem_port(mem_bus.device));
    bsram_host #(.DATA_W(DW)) u_bsram_host (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .run_i(run_i), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .wr_req_i(wr_req_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_lane_n_i(wr_lane_n_i),
        .rd_ack_o(rd_ack_o), .wr_ack_o(wr_ack_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .mem_port(mem_bus.host));
    bsram_if #(.DATA_W(NDW)) narrow_bus ();
    bsram_device #(.DATA_W(NDW)) u_bsram_device_narrow (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .mem_port(narrow_bus.device));
    bsram_host #(.DATA_W(NDW)) u_bsram_host_narrow (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .run_i(run_i), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .wr_req_i(wr_req_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i[NBW-1:0]),
        .wr_lane_n_i(wr_lane_n_i[NLW-1:0]), .rd_ack_o(n_rd_ack_o), .wr_ack_o(n_wr_ack_o),
        .rd_valid_o(n_rd_valid_o), .rd_data_o(n_rd_data_o), .mem_port(narrow_bus.host));
    bsram_port_props #(.DATA_W(DW)) u_bsram_port_props (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .k(mem_bus.k), .k_n(mem_bus.k_n), .addr(mem_bus.addr),
        .read_port_select_n(mem_bus.read_port_select_n),
        .write_port_select_n(mem_bus.write_port_select_n),
        .byte_lane_write_n(mem_bus.byte_lane_write_n), .wdata(mem_bus.wdata),
        .rdata(mem_bus.rdata), .rdata_oe_n(mem_bus.rdata_oe_n));
    // ==========================================================
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [BW-1:0] exp, input logic [BW-1:0] seen);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Waits for rd_ack (0), wr_ack (1) or rd_valid (2)
    task automatic wait_on(input int sel);
        for (int i = 0; i < 64; i++) begin
            @(negedge clock_i);
            if (((sel == 0) ? rd_ack_o : (sel == 1) ? wr_ack_o : rd_valid_o) === 1'b1) begin
                return;
            end
        end
        check("handshake", 1'b1, 1'b0);
        give_verdict();
    endtask
    task automatic do_write(input bsram_addr_t a, input logic [BW-1:0] d,
                            input logic [LW-1:0] ln);
        @(negedge clock_i);
        wr_addr_i = a;
        wr_data_i = d;
        wr_lane_n_i = ln;
        wr_req_i = 1'b1;
        wait_on(1);
        check("narrow write ack", 1'b1, n_wr_ack_o);
        wr_req_i = 1'b0;
        repeat (5) @(negedge clock_i);
    endtask
    task automatic do_read(input bsram_addr_t a, input logic [BW-1:0] exp);
        @(negedge clock_i);
        rd_addr_i = a;
        rd_req_i = 1'b1;
        wait_on(0);
        check("narrow read ack", 1'b1, n_rd_ack_o);
        rd_req_i = 1'b0;
        wait_on(2);
        check("read burst", exp, rd_data_o);
        check("narrow valid", 1'b1, n_rd_valid_o);
        check("narrow burst", BW'(exp[NBW-1:0]), BW'(n_rd_data_o));
    endtask
    function automatic logic [BW-1:0] merge(input logic [BW-1:0] old, input logic [BW-1:0] nw,
                                            input logic [LW-1:0] ln);
        logic [BW-1:0] r;
        r = old;
        for (int j = 0; j < LW; j++) begin
            if (!ln[j]) begin
                r[j*LANE_W +: LANE_W] = nw[j*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction
    task automatic pins_idle(input string what);
        check(what, 3'h7, {mem_bus.rdata_oe_n, mem_bus.read_port_select_n,
                           mem_bus.write_port_select_n});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_burst();
        do_write(6'h05, D1, '0);
        do_write(6'h06, ~D1, '0);
        do_read(6'h05, D1);
        do_read(6'h06, ~D1);
        mem5 = D1;
        $display("done burst");
    endtask
    task automatic t_mask();
        logic [LW-1:0] pat [2];
        pat[0] = 16'h7FBE;
        pat[1] = 16'hFFFF;
        for (int p = 0; p < 2; p++) begin
            do_write(6'h05, ~D1 ^ BW'(p), pat[p]);
            mem5 = merge(mem5, ~D1 ^ BW'(p), pat[p]);
            do_read(6'h05, mem5);
        end
        $display("done mask");
    endtask
    task automatic t_both();
        int rt;
        int wt;
        rt = 99;
        wt = -1;
        @(negedge clock_i);
        {rd_addr_i, wr_addr_i, wr_data_i, wr_lane_n_i} = {6'h05, 6'h09, D1, 16'h0000};
        {rd_req_i, wr_req_i} = 2'h3;
        for (int i = 0; i < 64 && (rd_req_i || wr_req_i); i++) begin
            @(negedge clock_i);
            if (rd_ack_o === 1'b1) begin
                rd_req_i = 1'b0;
                rt = i;
            end
            if (wr_ack_o === 1'b1) begin
                wr_req_i = 1'b0;
                wt = i;
            end
        end
        check("read first", 1'b1, rt < wt);
        wait_on(2);
        check("read burst", mem5, rd_data_o);
        check("narrow burst", BW'(mem5[NBW-1:0]), BW'(n_rd_data_o));
        do_read(6'h09, D1);
        $display("done both");
    endtask
    task automatic t_standby();
        check("clock pair", 1'b1, mem_bus.k ^ mem_bus.k_n);
        run_i = 1'b0;
        repeat (6) @(negedge clock_i);
        check("stopped clocks", 2'h3, {mem_bus.k, mem_bus.k_n});
        check("stopped output", 1'b1, mem_bus.rdata_oe_n);
        run_i = 1'b1;
        do_read(6'h05, mem5);
        $display("done standby");
    endtask
    task automatic t_reset_again();
        @(negedge clock_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        pins_idle("reset pins");
        reset_n_i = 1'b1;
        do_read(6'h05, mem5);
        $display("done reset");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(negedge clock_i);
        pins_idle("power-up pins");
        reset_n_i = 1'b1;
        t_burst();
        t_mask();
        t_both();
        t_standby();
        t_reset_again();
        give_verdict();
    end
endmodule
`default_nettype wire
